// ==== panel_keypad_consts.svh ====
// constants for the panel function keypad: offsets, fields, timing
`ifndef PANEL_KEYPAD_CONSTS_SVH
`define PANEL_KEYPAD_CONSTS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_ACTIVE 8'h04
`define OFS_STEREO 8'h08
`define OFS_CLINK 8'h0C
`define OFS_STATUS 8'h10
`define OFS_PASSWORD 8'h14

// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define CTRL_MASTER 0
`define CTRL_MANAGED 1
`define CTRL_MANUAL 2

// ---------------------------------------------------------------
// reset values and operation numbers
// ---------------------------------------------------------------
`define PW_DEFAULT 16'h0000
`define OP_CLEAR 5'h01
`define OP_MUTE 5'h02
`define OP_UNMUTE 5'h03
`define OP_LOCK 5'h09
`define OP_SETPW 5'h0A

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_HZ 25000000
`define BLINK_MS 250
`define STEP_MS 50
`define ACK_PHASES 8

`endif

// ==== panel_keypad_pkg.sv ====
// types shared by the panel function keypad
package panel_keypad_pkg;

  // edge or level view of every front panel key
  typedef struct packed {
    logic func;
    logic enter;
    logic cancel;
    logic other;
    logic [15:0] chan;
  } key_t;

  // every indicator driven by the block
  typedef struct packed {
    logic func;
    logic confirm;
    logic edit_lock;
    logic [15:0] chan;
    logic [15:0] meter;
    logic [13:0] clink;
  } led_t;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PEND = 3'b001,
    ST_SEL = 3'b010,
    ST_SWEEP = 3'b011,
    ST_ACK = 3'b100
  } state_t;

endpackage

// ==== panel_function_keypad.sv ====
// front panel function key sequencer with apb register access
`timescale 1ns/1ps
`include "panel_keypad_consts.svh"

module panel_function_keypad #(
  parameter int BLINK_CYC = `CLK_HZ / 1000 * `BLINK_MS,
  parameter int STEP_CYC = `CLK_HZ / 1000 * `STEP_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire panel_keypad_pkg::key_t keys,
  output panel_keypad_pkg::led_t leds,
  output logic [15:0] chan_active,
  output logic [7:0] stereo_link,
  output logic [13:0] control_link_channel,
  output logic [15:0] chan_mute,
  output logic net_locked
);
  import panel_keypad_pkg::*;

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  // lowest pressed channel key wins when several arrive together
  function automatic logic [3:0] chan_index(input logic [15:0] c);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (c[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // -------------------------------------------------------------
  // key synchronisers and press detection
  // -------------------------------------------------------------
  key_t key_s1_r; // first stage, read only by second
  key_t key_s2_r; // synchronised level
  key_t key_s3_r; // previous level for edge detect
  key_t ev; // one-cycle press events

  // panel keys are asynchronous, so two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_s1_r <= '0;
      key_s2_r <= '0;
      key_s3_r <= '0;
    end else begin
      key_s1_r <= keys;
      key_s2_r <= key_s1_r;
      key_s3_r <= key_s2_r;
    end
  end

  assign ev = key_s2_r & ~key_s3_r;

  // -------------------------------------------------------------
  // blink and sweep time bases
  // -------------------------------------------------------------
  logic [31:0] blink_cnt_r; // blink divider
  logic [31:0] step_cnt_r; // sweep step divider
  logic blink_r; // flash phase
  logic blink_tick; // one-cycle phase change
  logic step_tick; // one-cycle sweep step

  assign blink_tick = (blink_cnt_r == 32'(BLINK_CYC - 1));
  assign step_tick = (step_cnt_r == 32'(STEP_CYC - 1));

  // free running dividers; a shared base keeps all leds in phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt_r <= '0;
      step_cnt_r <= '0;
      blink_r <= 1'b0;
    end else begin
      blink_cnt_r <= blink_tick ? '0 : blink_cnt_r + 32'h1;
      step_cnt_r <= step_tick ? '0 : step_cnt_r + 32'h1;
      if (blink_tick) begin
        blink_r <= ~blink_r;
      end
    end
  end

  // -------------------------------------------------------------
  // control bits written by software; password and lock set from the keys
  // -------------------------------------------------------------
  logic master_r; // this module is network master
  logic managed_r; // centrally administered mode
  logic manual_r; // manual network mode, else automatic
  logic [15:0] pw_r; // four 4-bit entries, code 0 is key 1
  logic locked_r; // network lock

  // -------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------
  state_t state_r;
  logic [4:0] op_r; // selected op number, 1..16
  logic [15:0] ent_r; // entries keyed so far
  logic [2:0] ent_cnt_r; // entries counted, saturates at 4
  logic [4:0] anim_r; // animation step
  logic dir_r; // sweep direction, 1 is reverse
  logic any_chan;
  logic quit; // abandoning key during a request
  logic go; // confirm of a selected op
  logic ent_full;
  logic pw_ok;
  logic do_clear;
  logic do_mute;
  logic do_unmute;
  logic do_lock;
  logic do_unlock;
  logic do_setpw;

  assign any_chan = |ev.chan;
  assign quit = ev.cancel | ev.func | ev.other;
  assign go = (state_r == ST_SEL) && ev.enter && !quit;
  assign ent_full = (ent_cnt_r == 3'd4);
  assign pw_ok = ent_full && (ent_r == pw_r);
  assign do_clear = go && (op_r == `OP_CLEAR) && !locked_r
                    && !managed_r;
  assign do_mute = go && (op_r == `OP_MUTE);
  assign do_unmute = go && (op_r == `OP_UNMUTE);
  // master locks with its own password
  assign do_lock = go && (op_r == `OP_LOCK) && master_r
                   && !locked_r && pw_ok;
  assign do_unlock = go && (op_r == `OP_LOCK) && master_r
                     && locked_r && pw_ok;
  assign do_setpw = go && (op_r == `OP_SETPW) && !locked_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      op_r <= 5'h00;
      anim_r <= 5'h00;
      dir_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (ev.func) begin
            state_r <= ST_PEND;
          end
        end
        ST_PEND: begin
          if (ev.cancel | ev.func | ev.other | ev.enter) begin
            state_r <= ST_IDLE;
          end else if (any_chan) begin
            op_r <= {1'b0, chan_index(ev.chan)} + 5'h01;
            state_r <= ST_SEL;
          end
        end
        ST_SEL: begin
          if (quit) begin
            state_r <= ST_IDLE;
          end else if (ev.enter) begin
            anim_r <= 5'h00;
            dir_r <= do_unlock;
            if (do_lock | do_unlock) begin
              state_r <= ST_SWEEP;
            end else if (do_setpw) begin
              state_r <= ST_ACK;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_SWEEP: begin
          if (step_tick) begin
            anim_r <= anim_r + 5'h01;
            if (anim_r == 5'h0F) begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (blink_tick) begin
            anim_r <= anim_r + 5'h01;
            if (anim_r == 5'(`ACK_PHASES - 1)) begin
              state_r <= ST_IDLE;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // entry shifter keeps the latest four
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ent_r <= `PW_DEFAULT;
      ent_cnt_r <= 3'd0;
    end else if (state_r == ST_PEND) begin
      ent_r <= pw_r;
      ent_cnt_r <= 3'd0;
    end else if (state_r == ST_SEL && any_chan && !quit
                 && !ev.enter
                 && (op_r == `OP_LOCK || op_r == `OP_SETPW)) begin
      ent_r <= {ent_r[11:0], chan_index(ev.chan)};
      if (!ent_full) begin
        ent_cnt_r <= ent_cnt_r + 3'd1;
      end
    end
  end

  // -------------------------------------------------------------
  // apb slave, one wait state so read data leaves a flop
  // -------------------------------------------------------------
  logic acc; // access phase waiting for answer
  logic done; // completing edge of a transfer
  logic hit; // address is mapped
  logic [31:0] rd_nxt;

  assign acc = psel && penable && !pready;
  assign done = psel && penable && pready;

  // address decode shared by read mux and error answer
  always_comb begin
    hit = 1'b1;
    rd_nxt = 32'h0000_0000;
    if (paddr == `OFS_CTRL) begin
      rd_nxt = {29'h0, manual_r, managed_r, master_r};
    end else if (paddr == `OFS_ACTIVE) begin
      rd_nxt = {16'h0000, chan_active};
    end else if (paddr == `OFS_STEREO) begin
      rd_nxt = {24'h00_0000, stereo_link};
    end else if (paddr == `OFS_CLINK) begin
      rd_nxt = {18'h0, control_link_channel};
    end else if (paddr == `OFS_STATUS) begin
      rd_nxt = {21'h0, op_r, (&chan_mute), locked_r, 1'b0, state_r};
    end else if (paddr == `OFS_PASSWORD) begin
      rd_nxt = {16'h0000, pw_r};
    end else begin
      hit = 1'b0;
    end
  end

  // answer handshake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc;
      pslverr <= acc && !hit;
      if (acc && !pwrite) begin
        prdata <= rd_nxt;
      end
    end
  end

  // control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_r <= 1'b0;
      managed_r <= 1'b0;
      manual_r <= 1'b0;
    end else if (done && pwrite && paddr == `OFS_CTRL) begin
      master_r <= pwdata[`CTRL_MASTER];
      managed_r <= pwdata[`CTRL_MANAGED];
      manual_r <= pwdata[`CTRL_MANUAL];
    end
  end

  // resource tables; a confirmed clear beats a same-cycle write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_active <= 16'h0000;
      stereo_link <= 8'h00;
      control_link_channel <= 14'h0000;
    end else if (do_clear) begin
      chan_active <= 16'h0000;
      stereo_link <= 8'h00;
      control_link_channel <= 14'h0000;
    end else if (done && pwrite) begin
      if (paddr == `OFS_ACTIVE) begin
        chan_active <= pwdata[15:0];
      end else if (paddr == `OFS_STEREO) begin
        stereo_link <= pwdata[7:0];
      end else if (paddr == `OFS_CLINK) begin
        control_link_channel <= pwdata[13:0];
      end
    end
  end

  // all channels switch in one edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_mute <= 16'h0000;
    end else if (do_mute) begin
      chan_mute <= 16'hFFFF;
    end else if (do_unmute) begin
      chan_mute <= 16'h0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pw_r <= `PW_DEFAULT;
    end else if (do_setpw) begin
      pw_r <= ent_r;
    end
  end

  // lock holds until a matching unlock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked_r <= 1'b0;
    end else if (do_lock) begin
      locked_r <= 1'b1;
    end else if (do_unlock) begin
      locked_r <= 1'b0;
    end
  end

  assign net_locked = locked_r;

  // -------------------------------------------------------------
  // indicators
  // -------------------------------------------------------------
  led_t led_nxt;
  logic [15:0] sweep_bit;

  // forward sweep walks up, reverse walks down
  assign sweep_bit = 16'h0001 << (dir_r ? 4'hF - anim_r[3:0]
                                        : anim_r[3:0]);

  always_comb begin
    led_nxt = '0;
    led_nxt.edit_lock = locked_r;
    led_nxt.chan = chan_active;
    led_nxt.clink = control_link_channel;
    case (state_r)
      ST_PEND: begin
        led_nxt.func = blink_r;
        led_nxt.confirm = blink_r;
      end
      ST_SEL: begin
        led_nxt.func = blink_r;
        led_nxt.confirm = blink_r;
        if (op_r == `OP_CLEAR) begin
          // flash what a clear would remove
          led_nxt.chan = (chan_active | 16'h0001)
                         & {16{blink_r}};
          led_nxt.clink = control_link_channel & {14{blink_r}};
        end else if (op_r == `OP_LOCK && master_r && !locked_r) begin
          led_nxt.meter = blink_r ? 16'hAAAA : 16'h5555;
        end
      end
      ST_SWEEP: begin
        led_nxt.meter = sweep_bit;
      end
      ST_ACK: begin
        led_nxt.chan = {16{blink_r}};
      end
      default: begin
        led_nxt.func = 1'b0;
      end
    endcase
  end

  // every indicator leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      leds <= '0;
    end else begin
      leds <= led_nxt;
    end
  end

endmodule

// ==== panel_keys_model.sv ====
// front panel pushbutton model driving the raw key pins
`timescale 1ns/1ps
module panel_keys_model (
  input wire logic pclk,
  output panel_keypad_pkg::key_t keys
);
  import panel_keypad_pkg::*;
  // raw active high key levels, bit 19 func down to chan[0]
  logic [19:0] pins_r;
  assign keys = pins_r;
  initial pins_r = 20'h00000;
  // ---------------------------------------------------------------
  // one press: down just after an edge, held, then released
  // ---------------------------------------------------------------
  // keys in order
  // one key at a time, so the sequencer never sees a chord
  task automatic press(input int idx);
    @(posedge pclk);
    pins_r[idx] <= 1'b1;
    // held past the synchroniser and edge detector
    repeat (5) @(posedge pclk);
    pins_r[idx] <= 1'b0;
    // low long enough that the next press is a fresh edge
    repeat (5) @(posedge pclk);
  endtask
endmodule

// ==== panel_keypad_chk.sv ====
// concurrent checks on the panel function keypad ports
`timescale 1ns/1ps
module panel_keypad_chk #(
  parameter int BLINK_CYC = 4,
  parameter int STEP_CYC = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire panel_keypad_pkg::key_t keys,
  input wire panel_keypad_pkg::led_t leds,
  input wire logic [15:0] chan_active,
  input wire logic [7:0] stereo_link,
  input wire logic [13:0] control_link_channel,
  input wire logic [15:0] chan_mute,
  input wire logic net_locked
);
  import panel_keypad_pkg::*;
  // ---------------------------------------------------------------
  // one clock domain, reset disables everything
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb answers after exactly one wait state
  property p_apb_wait;
    psel && penable && !$past(penable) |-> !pready ##1 pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb wait wrong");
  // error only travels with ready
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("lone slverr");
  // mute table moves as a whole word
  property p_mute_whole;
    $changed(chan_mute) |-> chan_mute == 16'hFFFF || chan_mute == 16'h0000;
  endproperty
  a_mute_whole: assert property (p_mute_whole)
    else $error("partial mute");
  // mute changes only on a confirm press
  property p_mute_cause;
    $changed(chan_mute) |-> $past(keys.enter, 2);
  endproperty
  a_mute_cause: assert property (p_mute_cause)
    else $error("mute no enter");
  // while locked only software may touch the active table
  property p_lock_clear;
    $changed(chan_active) && $past(net_locked) |-> $past(pready && pwrite);
  endproperty
  a_lock_clear: assert property (p_lock_clear)
    else $error("clear locked");
  // a resource clear empties all three tables together
  property p_clear_all;
    $changed(stereo_link) && stereo_link == 8'h00 && !$past(pready && pwrite)
      |-> chan_active == 16'h0000 && control_link_channel == 14'h0000;
  endproperty
  a_clear_all: assert property (p_clear_all)
    else $error("partial clear");
  // lock lamp stays lit through the locked period
  property p_lamp;
    net_locked && $past(net_locked) && $past(net_locked, 2)
      |-> leds.edit_lock;
  endproperty
  a_lamp: assert property (p_lamp) else $error("lock lamp off");
  // lock sweep starts at the lowest meter
  property p_fwd;
    $rose(net_locked) |-> ##[0:3] leds.meter == 16'h0001;
  endproperty
  a_fwd: assert property (p_fwd) else $error("no forward sweep");
  // unlock sweep starts at the highest meter
  property p_rev;
    $fell(net_locked) |-> ##[0:3] leds.meter == 16'h8000;
  endproperty
  a_rev: assert property (p_rev) else $error("no reverse sweep");
  // lock state moves only on a confirm press
  property p_lock_cause;
    $changed(net_locked) |-> $past(keys.enter, 2);
  endproperty
  a_lock_cause: assert property (p_lock_cause)
    else $error("lock no enter");
endmodule
bind panel_function_keypad panel_keypad_chk #(.BLINK_CYC(BLINK_CYC),
  .STEP_CYC(STEP_CYC)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .keys(keys),
  .leds(leds), .chan_active(chan_active), .stereo_link(stereo_link),
  .control_link_channel(control_link_channel), .chan_mute(chan_mute),
  .net_locked(net_locked));

// ==== tb_top.sv ====
// self-checking bench for the panel function keypad
`timescale 1ns/1ps
`include "panel_keypad_consts.svh"
module tb_top;
  import panel_keypad_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, net_locked;
  key_t keys;
  led_t leds;
  logic [15:0] chan_active, chan_mute, act;
  logic [7:0] stereo_link;
  logic [13:0] control_link_channel;
  int error_cnt = 0;
  int checks_done = 0;
  int seed = 99826;
  int n, tg_f, tg_c;
  int pw[4];
  // key pin positions inside key_t, function key is the msb
  localparam int K_FUNC = 19;
  localparam int K_ENTER = 18;
  localparam int K_CANCEL = 17;
  localparam int K_OTHER = 16;
  always #20 pclk = ~pclk;
  // short blink and sweep counts keep the run brief
  panel_function_keypad #(.BLINK_CYC(4), .STEP_CYC(3)) dut_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .keys(keys), .leds(leds), .chan_active(chan_active),
    .stereo_link(stereo_link), .control_link_channel(control_link_channel),
    .chan_mute(chan_mute), .net_locked(net_locked));
  panel_keys_model pk_u (.pclk(pclk), .keys(keys));
  // ---------------------------------------------------------------
  // verdict, compare and bus helpers
  // ---------------------------------------------------------------
  task automatic complete_run();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // full apb transfer, released only after pready is sampled
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // a spare edge so back-to-back calls never double-assign psel
    @(posedge pclk);
    if (i >= 50) begin
      error_cnt++;
      complete_run();
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // poll until sweeps and acknowledge patterns have finished
  task automatic wait_idle();
    n = 0;
    do begin
      apb(1'b0, `OFS_STATUS, 32'h0);
      n++;
    end while (rd[2:0] !== 3'b000 && n < 100);
    if (n >= 100) begin
      error_cnt++;
      complete_run();
    end
  endtask
  task automatic sel(input int op);
    pk_u.press(K_FUNC);
    pk_u.press(op - 1);
  endtask
  // op nine with the four entries held in pw; warn says whether the
  // lock warning pattern must be showing once the op is selected
  task automatic lock_try(input logic warn);
    sel(9);
    @(posedge pclk);
    chk(leds.meter == 16'hAAAA || leds.meter == 16'h5555, warn);
    foreach (pw[i]) pk_u.press(pw[i]);
    pk_u.press(K_ENTER);
    wait_idle();
  endtask
  // first entry sits in the top nibble, key k codes as k minus one
  function automatic logic [31:0] pw_word();
    return {16'h0000, 4'(pw[0]), 4'(pw[1]), 4'(pw[2]), 4'(pw[3])};
  endfunction
  initial begin
    #(40 * 100000);
    error_cnt++;
    complete_run();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(`OFS_PASSWORD, {16'h0000, `PW_DEFAULT});
    act = 16'($random(seed));
    apb(1'b1, `OFS_ACTIVE, {16'h0000, act});
    apb(1'b1, `OFS_STEREO, 32'h0000005A);
    apb(1'b1, `OFS_CLINK, 32'h00003FFF);
    rdchk(`OFS_ACTIVE, {16'h0000, act});
    apb(1'b0, 8'h18, 32'h0);
    chk(err, 1'b1);
    pk_u.press(K_FUNC);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(rd[2:0], 3'h1);
    pk_u.press(K_OTHER);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(rd[2:0], 3'h0);
    sel(2);
    tg_f = 0;
    tg_c = 0;
    repeat (16) begin
      @(posedge pclk);
      tg_f += (leds.func === 1'b1);
      tg_c += (leds.confirm === 1'b1);
    end
    chk(tg_f > 3 && tg_f < 13 && tg_c > 3 && tg_c < 13, 1'b1);
    pk_u.press(K_CANCEL);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(rd[2:0], 3'h0);
    // a late confirm must find nothing pending
    pk_u.press(K_ENTER);
    chk(chan_mute, 16'h0000);
    sel(2);
    pk_u.press(K_ENTER);
    chk(chan_mute, 16'hFFFF);
    sel(3);
    pk_u.press(K_ENTER);
    chk(chan_mute, 16'h0000);
    for (int k = 4; k <= 8; k++) begin
      sel(k);
      pk_u.press(K_ENTER);
      chk({chan_mute, chan_active}, {16'h0000, act});
    end
    // clear refused when managed, done otherwise
    apb(1'b1, `OFS_CTRL, 32'h00000002);
    sel(1);
    pk_u.press(K_ENTER);
    chk(chan_active, act);
    apb(1'b1, `OFS_CTRL, 32'h00000000);
    sel(1);
    // what a clear would remove flashes, on and off
    tg_f = 0;
    tg_c = 0;
    repeat (8) begin
      @(posedge pclk);
      tg_f += (leds.chan === (act | 16'h0001) && leds.clink === 14'h3FFF);
      tg_c += (leds.chan === 16'h0000 && leds.clink === 14'h0000);
    end
    chk(tg_f > 0 && tg_c > 0, 1'b1);
    pk_u.press(K_ENTER);
    chk({chan_active, stereo_link}, 24'h0);
    chk(control_link_channel, 14'h0000);
    apb(1'b1, `OFS_ACTIVE, {16'h0000, act});
    apb(1'b1, `OFS_CTRL, 32'h00000001);
    pw = '{0, 0, 0, 0};
    lock_try(1'b1);
    chk({net_locked, leds.edit_lock}, 2'b11);
    sel(1);
    pk_u.press(K_ENTER);
    chk(chan_active, act);
    sel(10);
    repeat (4) pk_u.press(5);
    pk_u.press(K_ENTER);
    wait_idle();
    rdchk(`OFS_PASSWORD, 32'h0);
    pw = '{1, 1, 1, 1};
    lock_try(1'b0);
    chk(net_locked, 1'b1);
    pw = '{0, 0, 0, 0};
    lock_try(1'b0);
    chk(net_locked, 1'b0);
    // five keys, last four kept, abort keeps it
    sel(10);
    pk_u.press(7);
    foreach (pw[i]) pw[i] = $unsigned($random(seed)) % 16;
    foreach (pw[i]) pk_u.press(pw[i]);
    pk_u.press(K_ENTER);
    // channel keys flash while the new password is acknowledged
    tg_f = 0;
    repeat (8) begin
      @(posedge pclk);
      tg_f += (leds.chan === 16'hFFFF);
    end
    chk(tg_f > 0 && tg_f < 8, 1'b1);
    wait_idle();
    rdchk(`OFS_PASSWORD, pw_word());
    sel(10);
    repeat (4) pk_u.press(3);
    pk_u.press(K_CANCEL);
    rdchk(`OFS_PASSWORD, pw_word());
    apb(1'b1, `OFS_CTRL, 32'h00000000);
    lock_try(1'b0);
    chk(net_locked, 1'b0);
    complete_run();
  end
endmodule
